// [rtl/svs_pkg.sv]
// Register map, field layout and types of the supply voltage sensor
package svs_pkg;

    // Register indices; byte address is four times the index
    localparam logic [2:0] IDX_PATH_ENABLE = 3'h0;
    localparam logic [2:0] IDX_COND_STATUS = 3'h1;
    localparam logic [2:0] IDX_IRQ_ENABLE = 3'h2;
    localparam logic [2:0] IDX_IRQ_FLAGS = 3'h3;
    localparam logic [2:0] IDX_RSVD_ZERO = 3'h4;
    localparam logic [2:0] IDX_RSVD_SPECIAL = 3'h6;
    localparam int WINDOW_WORDS = 8;

    // Path enable register field positions
    localparam int BIT_SENSE_LVL = 0;
    localparam int BIT_SENSE_CONV = 1;
    localparam int BIT_CHIP_LVL = 2;
    localparam int BIT_CHIP_CONV = 3;
    localparam int BIT_LOW_SEL_LO = 4;
    localparam int BIT_LOW_SEL_HI = 5;
    localparam int BIT_HIGH_SEL = 6;

    // Condition, irq enable and flag registers share this layout
    localparam int BIT_LOW = 0;
    localparam int BIT_HIGH = 1;

    // Reset values
    localparam logic [6:0] PATH_ENABLE_RST = 7'h00;
    localparam logic [1:0] IRQ_ENABLE_RST = 2'h0;
    localparam logic [1:0] IRQ_FLAGS_RST = 2'h0;
    localparam logic [1:0] COND_RST = 2'h0;

    // Trip level encodings
    localparam logic [1:0] LOW_TRIP_LEVEL1 = 2'h0;
    localparam logic [1:0] LOW_TRIP_LEVEL2 = 2'h1;
    localparam logic [1:0] LOW_TRIP_LEVEL3 = 2'h2;
    localparam logic [1:0] LOW_TRIP_LEVEL4 = 2'h3;
    localparam logic HIGH_TRIP_LEVEL1 = 1'b0;
    localparam logic HIGH_TRIP_LEVEL2 = 1'b1;

    typedef struct packed {
        logic highTripSel;
        logic [1:0] lowTripSel;
        logic chipConv;
        logic chipLvl;
        logic senseConv;
        logic senseLvl;
    } svs_cfg_t;

    // Controls toward the divider, comparator mux and converter mux
    typedef struct packed {
        logic senseDividerClose;
        logic supplyDividerClose;
        logic levelSenseEnable;
        logic levelSrcSense;
        logic adcConnect;
        logic adcSrcSense;
        logic highTripSel;
        logic [1:0] lowTripSel;
    } svs_analog_t;

endpackage // svs_pkg

// [rtl/svs_supply_sensor.sv]
// Supply voltage sensor register block with APB slave and interrupt
// How it works
// - Sense pin enable closes sense divider path
// - Chip pin enable closes supply divider path
// - Sense level enable beats chip level enable
// - Sense converter enable beats chip converter enable
// - Stop mode opens paths, disables level sensing
// - Configuration kept unchanged through stop mode
// - Either pin routed to converter channel
// - One pin routed to comparator, raises irqs
// - Base plus offset decode, functional offsets 0..3
// - Unimplemented bits read as zero
// - Low trip select is two bits
// - High trip select at enable bit six
// - Flags set on condition change, write-one-clear
// - Flag with enable set requests interrupt
// - Sense enable clears chip enable counterpart
// - Trip select codes pick trip levels
//
// Design decision made here: the APB interface to the registers.
module svs_supply_sensor #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System power mode
    input wire logic stopMode,
    // Comparator results for selected trip levels
    input wire logic highCmpIn,
    input wire logic lowCmpIn,
    // Analog controls
    output svs_pkg::svs_analog_t analogCtrl,
    // Interrupt request
    output logic irq
);

    svs_pkg::svs_cfg_t cfg_r;
    svs_pkg::svs_cfg_t cfg_nxt;
    logic [1:0] irqEnable_r;
    logic [1:0] irqFlags_r;
    logic [1:0] cmpMeta_r;
    logic [1:0] cond_r;
    logic [1:0] condPrev_r;
    logic [1:0] condChange;
    logic [31:0] rdData_nxt;
    logic [2:0] regIdx;
    logic inWindow;
    logic setupPhase;
    logic accessWr;
    logic wrPath;
    logic wrFlags;
    logic wrIrqEn;
    logic wrLane0;
    logic [1:0] flagClear;

    // Word index within the window; upper address bits must be zero
    function automatic logic window_hit(input logic [ADDR_W-1:0] addr);
        window_hit = (addr[ADDR_W-1:2] < (ADDR_W-2)'(svs_pkg::WINDOW_WORDS)) && (addr[1:0] == 2'h0);
    endfunction

    assign regIdx = paddr[4:2];
    assign inWindow = window_hit(paddr);
    assign setupPhase = psel && !penable;
    assign accessWr = psel && penable && pwrite && inWindow;
    assign wrLane0 = pstrb[0];
    // Reserved words decode to nothing, so writes there are dropped
    assign wrPath = accessWr && wrLane0 && (regIdx == svs_pkg::IDX_PATH_ENABLE);
    assign wrIrqEn = accessWr && wrLane0 && (regIdx == svs_pkg::IDX_IRQ_ENABLE);
    assign wrFlags = accessWr && wrLane0 && (regIdx == svs_pkg::IDX_IRQ_FLAGS);

    // Zero wait states; unaligned or out-of-window access errors
    assign pready = 1'b1;
    assign pslverr = psel && penable && !inWindow;

    // Enable write with mutual exclusion of paired enables
    always_comb
    begin
        cfg_nxt = cfg_r;
        if (wrPath)
        begin
            cfg_nxt.highTripSel = pwdata[svs_pkg::BIT_HIGH_SEL];
            cfg_nxt.lowTripSel = pwdata[svs_pkg::BIT_LOW_SEL_HI:svs_pkg::BIT_LOW_SEL_LO];
            cfg_nxt.senseLvl = pwdata[svs_pkg::BIT_SENSE_LVL];
            cfg_nxt.senseConv = pwdata[svs_pkg::BIT_SENSE_CONV];
            cfg_nxt.chipLvl = pwdata[svs_pkg::BIT_CHIP_LVL] && !pwdata[svs_pkg::BIT_SENSE_LVL];
            cfg_nxt.chipConv = pwdata[svs_pkg::BIT_CHIP_CONV] && !pwdata[svs_pkg::BIT_SENSE_CONV];
        end
    end

    // Stop mode leaves the stored settings alone
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_r <= svs_pkg::svs_cfg_t'(svs_pkg::PATH_ENABLE_RST);
        else
            cfg_r <= cfg_nxt;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            irqEnable_r <= svs_pkg::IRQ_ENABLE_RST;
        else if (wrIrqEn)
            irqEnable_r <= pwdata[1:0];
    end

    // Two-flop synchroniser for the comparator outputs
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmpMeta_r <= svs_pkg::COND_RST;
            cond_r <= svs_pkg::COND_RST;
            condPrev_r <= svs_pkg::COND_RST;
        end
        else
        begin
            cmpMeta_r <= {highCmpIn, lowCmpIn};
            cond_r <= cmpMeta_r;
            condPrev_r <= cond_r;
        end
    end

    assign condChange = cond_r ^ condPrev_r;
    assign flagClear = wrFlags ? pwdata[1:0] : 2'h0;

    // A change in the clearing cycle wins over the clear
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            irqFlags_r <= svs_pkg::IRQ_FLAGS_RST;
        else
            irqFlags_r <= (irqFlags_r & ~flagClear) | condChange;
    end

    assign irq = |(irqFlags_r & irqEnable_r);

    // Analog controls; stop forces every path open
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            analogCtrl <= '0;
        else
        begin
            analogCtrl.senseDividerClose <= !stopMode && (cfg_nxt.senseLvl || cfg_nxt.senseConv);
            analogCtrl.supplyDividerClose <= !stopMode && (cfg_nxt.chipLvl || cfg_nxt.chipConv);
            analogCtrl.levelSenseEnable <= !stopMode && (cfg_nxt.senseLvl || cfg_nxt.chipLvl);
            analogCtrl.levelSrcSense <= cfg_nxt.senseLvl;
            analogCtrl.adcConnect <= !stopMode && (cfg_nxt.senseConv || cfg_nxt.chipConv);
            analogCtrl.adcSrcSense <= cfg_nxt.senseConv;
            analogCtrl.highTripSel <= cfg_nxt.highTripSel;
            analogCtrl.lowTripSel <= cfg_nxt.lowTripSel;
        end
    end

    // Read data captured in the setup phase
    always_comb
    begin
        rdData_nxt = 32'h0000_0000;
        if (inWindow)
        begin
            case (regIdx)
                svs_pkg::IDX_PATH_ENABLE: rdData_nxt[6:0] = cfg_r;
                svs_pkg::IDX_COND_STATUS: rdData_nxt[1:0] = cond_r;
                svs_pkg::IDX_IRQ_ENABLE: rdData_nxt[1:0] = irqEnable_r;
                svs_pkg::IDX_IRQ_FLAGS: rdData_nxt[1:0] = irqFlags_r;
                default: rdData_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= 32'h0000_0000;
        else if (setupPhase)
            prdata <= rdData_nxt;
    end

    // Checks
    sequence s_sense_write;
        wrPath && pwdata[svs_pkg::BIT_SENSE_LVL] && !stopMode;
    endsequence

    sequence s_chip_write;
        wrPath && pwdata[svs_pkg::BIT_CHIP_LVL] && !pwdata[svs_pkg::BIT_SENSE_LVL] && !stopMode;
    endsequence

    a_sense_path_close: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_sense_write ##1 !stopMode |-> analogCtrl.senseDividerClose && analogCtrl.levelSrcSense)
        else $error("sense divider not closed after enable");

    a_supply_path_close: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_chip_write ##1 !stopMode |-> analogCtrl.supplyDividerClose && !analogCtrl.levelSrcSense)
        else $error("supply divider not closed after enable");

    a_level_priority: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrPath && pwdata[svs_pkg::BIT_SENSE_LVL] && pwdata[svs_pkg::BIT_CHIP_LVL]
        |=> !cfg_r.chipLvl && analogCtrl.levelSrcSense)
        else $error("chip level enable survived sense level enable");

    a_conv_priority: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrPath && pwdata[svs_pkg::BIT_SENSE_CONV] && pwdata[svs_pkg::BIT_CHIP_CONV]
        |=> !cfg_r.chipConv && analogCtrl.adcSrcSense)
        else $error("chip converter enable survived sense converter enable");

    a_stop_open_paths: assert property (@(posedge ref_clk) disable iff (!rst_n)
        stopMode |=> !analogCtrl.senseDividerClose && !analogCtrl.supplyDividerClose
        && !analogCtrl.levelSenseEnable && !analogCtrl.adcConnect)
        else $error("path closed during stop");

    a_stop_keeps_cfg: assert property (@(posedge ref_clk) disable iff (!rst_n)
        stopMode && !wrPath |=> $stable(cfg_r))
        else $error("configuration changed in stop");

    a_flag_on_change: assert property (@(posedge ref_clk) disable iff (!rst_n)
        condChange[svs_pkg::BIT_HIGH]
        |=> irqFlags_r[svs_pkg::BIT_HIGH])
        else $error("high flag not set on condition change");

    a_flag_w1c: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrFlags && pwdata[svs_pkg::BIT_LOW] && !condChange[svs_pkg::BIT_LOW]
        |=> !irqFlags_r[svs_pkg::BIT_LOW])
        else $error("low flag not cleared by write one");

    a_irq_request: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrIrqEn && pwdata[svs_pkg::BIT_HIGH] ##1 irqFlags_r[svs_pkg::BIT_HIGH] |-> irq)
        else $error("enabled flag did not request interrupt");

    a_reserved_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        setupPhase && !pwrite && regIdx[2] |=> prdata == 32'h0000_0000)
        else $error("reserved offset read nonzero");

    a_pready_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
        psel && penable |-> pready)
        else $error("pready low in access phase");

    a_slverr_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        psel && penable && !inWindow |-> pslverr)
        else $error("no error on access outside window");

    a_slverr_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        psel && penable && inWindow |-> !pslverr)
        else $error("error on access inside window");

    a_outside_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        setupPhase && !inWindow |=> prdata == 32'h0000_0000)
        else $error("read outside window nonzero");

    a_enable_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        setupPhase && inWindow && (regIdx == svs_pkg::IDX_PATH_ENABLE)
        |=> prdata == {25'h0000000, $past(cfg_r)})
        else $error("enable register read wrong");

    a_status_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        setupPhase && inWindow && (regIdx == svs_pkg::IDX_COND_STATUS)
        |=> prdata == {30'h00000000, $past(cond_r)})
        else $error("status register read wrong");

    a_irqen_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        setupPhase && inWindow && (regIdx == svs_pkg::IDX_IRQ_ENABLE)
        |=> prdata == {30'h00000000, $past(irqEnable_r)})
        else $error("irq enable register read wrong");

    a_flags_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        setupPhase && inWindow && (regIdx == svs_pkg::IDX_IRQ_FLAGS)
        |=> prdata == {30'h00000000, $past(irqFlags_r)})
        else $error("flag register read wrong");

    a_upper_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        prdata[31:7] == 25'h0000000)
        else $error("unimplemented read bits nonzero");

    // Both earlier edges must be out of reset, else the history is stale
    a_cond_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(rst_n) && $past(rst_n, 2) |-> cond_r == $past({highCmpIn, lowCmpIn}, 2))
        else $error("condition not a synchronised comparator copy");

    a_low_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        condChange[svs_pkg::BIT_LOW] |=> irqFlags_r[svs_pkg::BIT_LOW])
        else $error("low flag not set on condition change");

    a_flag_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        irqFlags_r[svs_pkg::BIT_HIGH] && !(wrFlags && pwdata[svs_pkg::BIT_HIGH]) |=> irqFlags_r[svs_pkg::BIT_HIGH])
        else $error("high flag lost without clear");

    a_flag_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !irqFlags_r[svs_pkg::BIT_LOW] && !condChange[svs_pkg::BIT_LOW] |=> !irqFlags_r[svs_pkg::BIT_LOW])
        else $error("low flag set without change");

    a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
        irqFlags_r[svs_pkg::BIT_LOW] && irqEnable_r[svs_pkg::BIT_LOW] |-> irq)
        else $error("enabled low flag did not request interrupt");

    a_irq_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(|(irqFlags_r & irqEnable_r)) |-> !irq)
        else $error("interrupt without enabled flag");

    a_sense_conv_close: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrPath && pwdata[svs_pkg::BIT_SENSE_CONV] && !stopMode
        |=> analogCtrl.senseDividerClose && analogCtrl.adcConnect && analogCtrl.adcSrcSense)
        else $error("sense converter path not closed");

    a_chip_conv_close: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrPath && pwdata[svs_pkg::BIT_CHIP_CONV] && !pwdata[svs_pkg::BIT_SENSE_CONV] && !stopMode
        |=> analogCtrl.supplyDividerClose && analogCtrl.adcConnect && !analogCtrl.adcSrcSense)
        else $error("supply converter path not closed");

    a_sense_open_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(cfg_nxt.senseLvl || cfg_nxt.senseConv) |=> !analogCtrl.senseDividerClose)
        else $error("sense divider closed without enable");

    a_supply_open_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(cfg_nxt.chipLvl || cfg_nxt.chipConv) |=> !analogCtrl.supplyDividerClose)
        else $error("supply divider closed without enable");

    a_adc_open_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(cfg_nxt.senseConv || cfg_nxt.chipConv) |=> !analogCtrl.adcConnect)
        else $error("converter connected without enable");

    a_level_run: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !stopMode && (cfg_nxt.senseLvl || cfg_nxt.chipLvl) |=> analogCtrl.levelSenseEnable)
        else $error("level sensing off while enabled in run");

    a_trip_copy: assert property (@(posedge ref_clk) disable iff (!rst_n)
        analogCtrl.lowTripSel == cfg_r.lowTripSel && analogCtrl.highTripSel == cfg_r.highTripSel)
        else $error("trip selects differ from configuration");

    a_low_sel_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrPath |=> cfg_r.lowTripSel == $past(pwdata[svs_pkg::BIT_LOW_SEL_HI:svs_pkg::BIT_LOW_SEL_LO]))
        else $error("low trip select not stored");

    a_high_sel_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrPath |=> cfg_r.highTripSel == $past(pwdata[svs_pkg::BIT_HIGH_SEL]))
        else $error("high trip select not stored");

    a_cfg_exclusive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(cfg_r.senseLvl && cfg_r.chipLvl) && !(cfg_r.senseConv && cfg_r.chipConv))
        else $error("paired enables both set");

    a_reserved_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        accessWr && regIdx[2] |=> $stable(cfg_r) && $stable(irqEnable_r))
        else $error("reserved write changed a register");

    a_cfg_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !wrPath |=> $stable(cfg_r))
        else $error("configuration changed without write");

endmodule // svs_supply_sensor

// [dv/svs_analog_model.sv]
// Behavioural divider and comparator facing the supply voltage sensor
module svs_analog_model (
    // Controls from the sensor block
    input wire svs_pkg::svs_analog_t analogCtrl,
    // Measured level, larger code means higher voltage
    input wire logic [7:0] level,
    // Comparator results
    output logic highCmpIn,
    output logic lowCmpIn
);
    logic [7:0] highThr;
    logic [7:0] lowThr;
    // Four low levels eight codes apart, two high levels
    assign highThr = analogCtrl.highTripSel ? 8'ha0 : 8'h80;
    assign lowThr = 8'h20 + {3'h0, analogCtrl.lowTripSel, 3'h0};
    // Open divider gives no trip, so a stuck enable shows up
    assign highCmpIn = analogCtrl.levelSenseEnable & (level >= highThr);
    assign lowCmpIn = analogCtrl.levelSenseEnable & (level < lowThr);
endmodule // svs_analog_model

// [dv/tb_top.sv]
// Self-checking bench for the supply voltage sensor register block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, stopMode, highCmpIn, lowCmpIn, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] level;
    svs_pkg::svs_analog_t analogCtrl;
    int errTotal = 0;
    int nCompared = 0;
    int cyc = 0;

    svs_supply_sensor svs_supply_sensor_inst (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .stopMode(stopMode),
        .highCmpIn(highCmpIn), .lowCmpIn(lowCmpIn), .analogCtrl(analogCtrl), .irq(irq));
    svs_analog_model svs_analog_model_inst (.analogCtrl(analogCtrl), .level(level),
        .highCmpIn(highCmpIn), .lowCmpIn(lowCmpIn));

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic results;
        $display("Compared %0d, mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        nCompared++;
        if (g !== x)
        begin
            errTotal++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] x, input string n);
        xfer(a, 1'b0, 32'h0);
        chk(n, x, rd);
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errTotal++;
            results();
        end
    end

    initial
    begin
        {psel, penable, pwrite, stopMode, rst_n} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        level = 8'h40;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdc(12'h000, 32'h0, "enable");
        rdc(12'h004, 32'h0, "status");
        rdc(12'h008, 32'h0, "irqEnable");
        rdc(12'h00c, 32'h0, "flags");
        wr(12'h000, 32'h7f);
        rdc(12'h000, 32'h73, "enable");
        chk("analog", 32'h17f, analogCtrl);
        wr(12'h000, 32'h0c);
        rdc(12'h000, 32'h0c, "enable");
        chk("analog", 32'h0d0, analogCtrl);
        stopMode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("analogStop", 32'h0, analogCtrl);
        stopMode <= 1'b0;
        rdc(12'h000, 32'h0c, "enable");
        chk("analog", 32'h0d0, analogCtrl);
        for (int c = 0; c < 4; c++)
        begin
            wr(12'h000, {26'h0, c[1:0], 4'h1});
            level <= 8'h1f + 8'(c * 8);
            repeat (5) @(posedge ref_clk);
            rdc(12'h004, 32'h1, "lowCond");
        end
        level <= 8'h40;
        repeat (5) @(posedge ref_clk);
        wr(12'h010, 32'hff);
        rdc(12'h010, 32'h0, "reserved");
        rdc(12'h018, 32'h0, "reserved");
        wr(12'h004, 32'hff);
        rdc(12'h004, 32'h0, "status");
        xfer(12'h020, 1'b0, 32'h0);
        chk("slverr", 32'h1, e);
        chk("unmapped", 32'h0, rd);
        wr(12'h000, 32'h01);
        wr(12'h00c, 32'h03);
        wr(12'h008, 32'h03);
        rdc(12'h008, 32'h3, "irqEnable");
        level <= 8'h90;
        repeat (5) @(posedge ref_clk);
        rdc(12'h004, 32'h2, "status");
        rdc(12'h00c, 32'h2, "flags");
        chk("irq", 32'h1, irq);
        wr(12'h00c, 32'h01);
        rdc(12'h00c, 32'h2, "flags");
        wr(12'h00c, 32'h02);
        rdc(12'h00c, 32'h0, "flags");
        chk("irq", 32'h0, irq);
        wr(12'h008, 32'h01);
        level <= 8'h40;
        repeat (5) @(posedge ref_clk);
        rdc(12'h00c, 32'h2, "flags");
        chk("irqMasked", 32'h0, irq);
        wr(12'h008, 32'h03);
        repeat (2) @(posedge ref_clk);
        chk("irq", 32'h1, irq);
        results();
    end
endmodule // tb_top
